// File: core/tps_link_supervisor.sv
// twisted pair link supervisor: squelch, collision, heartbeat, link, jabber, pre-emphasis
// assumes analog comparators on the receive pair, a codec on pclk and an APB master
// Function
// - after first threshold crossing, reject unless opposite crossing follows within 150 ns
// - then the original polarity must be crossed again within another 150 ns
// - valid data asserted only after the full sequence; sequencer resets then
// - valid data held until no crossing for more than 150 ns
// - lowered thresholds used for the rest of a packet once valid
// - standard or reduced threshold mode selectable; timing identical in both
// - collision when receive and transmit are active together
// - collision while receiving reported at once
// - collision while transmitting reported after seven bit times
// - collision indication held while the condition lasts
// - about 1 us after transmit ends, ten 10 MHz heartbeat cycles
// - idle transmitter sends a 100 ns link pulse every 16 ms
// - missing link pulses disable transmit, receive and collision detection
// - link good indicator active while the link is good
// - link check disable bypasses link integrity gating
// - transmitter disabled when active for more than 26 ms
// - after a trip, stays disabled while transmit enable is asserted
// - re-enabled after transmit enable low for about 750 ms
// - true/complement data pair plus a copy delayed by 50 ns
// - separate indicators for receive, transmit, collision, link and polarity
//
// The address map and register access over APB were decided locally.
`timescale 1ns/100ps
`include "tps_cfg.svh"

module tps_link_supervisor #(
	parameter logic [20:0] LP_PERIOD_CYC = 21'(`TPS_LP_PERIOD_CYC),
	parameter logic [23:0] LINK_LOSS_CYC = 24'(`TPS_LINK_LOSS_CYC),
	parameter logic [26:0] JAB_CYC       = 27'(`TPS_JAB_CYC),
	parameter logic [26:0] UNJAB_CYC     = 27'(`TPS_UNJAB_CYC)
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_squelch_pos,
	input  wire logic        rx_squelch_neg,
	input  wire logic        link_pulse_rx,
	input  wire logic        codec_tx_enable,
	input  wire logic        codec_tx_data,
	output logic             rx_data_valid,
	output logic             mac_collision,
	output logic             sqe_heartbeat,
	output logic      [1:0]  squelch_level_sel,
	output logic             tx_line_pair_p,
	output logic             tx_line_pair_n,
	output logic             tx_line_pair_delayed_p,
	output logic             tx_line_pair_delayed_n,
	output logic             receive_activity_indicator,
	output logic             transmit_activity_indicator,
	output logic             collision_indicator,
	output logic             link_good_indicator,
	output logic             polarity_indicator
);

	localparam logic [4:0] SQ_WIN  = 5'(`TPS_SQ_WIN_CYC);
	localparam logic [6:0] COL_CYC = 7'(`TPS_COL_CYC);
	localparam logic [7:0] HB_DLY  = 8'(`TPS_HB_DLY_CYC);
	localparam logic [7:0] HB_END  = 8'(`TPS_HB_DLY_CYC + `TPS_HB_LEN_CYC);
	localparam logic [3:0] HB_HALF = 4'(`TPS_HB_HALF_CYC);
	localparam logic [20:0] LP_W   = 21'(`TPS_LP_W_CYC);
	localparam int PRE_N           = `TPS_PRE_DLY_CYC;

	// three-stage input synchronisers, a change counts once stages two and three agree
	logic [2:0] async_in;
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync3;
	logic [2:0] filt;
	logic [2:0] next_filt;
	assign async_in = {link_pulse_rx, rx_squelch_neg, rx_squelch_pos};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_comb
			begin
				next_filt[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : filt[gi];
			end
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
					sync3[gi] <= 1'b0;
					filt[gi]  <= 1'b0;
				end
				else
				begin
					sync1[gi] <= async_in[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					filt[gi]  <= next_filt[gi];
				end
			end
		end
	endgenerate

	logic sq_pos;
	logic sq_neg;
	logic lp_seen;
	assign sq_pos  = filt[0];
	assign sq_neg  = filt[1];
	assign lp_seen = filt[2];

	// apb slave and control register; one wait-free access, pready raised in the access phase
	logic [1:0]  ctrl;
	logic [1:0]  next_ctrl;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic [5:0]  status;
	logic        mapped;
	logic        reduced_squelch_select;
	logic        link_check_disable;
	assign reduced_squelch_select = ctrl[`TPS_CTRL_REDUCED];
	assign link_check_disable     = ctrl[`TPS_CTRL_LINK_OFF];
	assign mapped = (paddr == `TPS_OFS_CTRL) || (paddr == `TPS_OFS_STATUS);

	always_comb
	begin
		next_ctrl    = ctrl;
		next_prdata  = prdata;
		next_pready  = psel && !penable;
		next_pslverr = psel && !penable && !mapped;
		if (psel && !penable && !pwrite)
		begin
			next_prdata = 32'h0;
			if (paddr == `TPS_OFS_CTRL)
				next_prdata[1:0] = ctrl;
			else if (paddr == `TPS_OFS_STATUS)
				next_prdata[5:0] = status;
		end
		// write lands at the edge that samples pready, byte lane 0 only
		if (psel && penable && pready && pwrite && pstrb[0] && paddr == `TPS_OFS_CTRL)
			next_ctrl = pwdata[1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl    <= `TPS_CTRL_RESET;
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			ctrl    <= next_ctrl;
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// link integrity; starts failed so traffic waits for the first pulse
	logic [20:0] lp_cnt;
	logic [20:0] next_lp_cnt;
	logic [23:0] loss_cnt;
	logic [23:0] next_loss_cnt;
	logic        link_fail;
	logic        next_link_fail;
	logic        lp_seen_q;
	logic        link_ok;
	logic        lp_on;
	logic        jab;
	assign link_ok = link_check_disable || !link_fail;
	assign lp_on   = (lp_cnt >= LP_PERIOD_CYC - LP_W) && !codec_tx_enable;

	always_comb
	begin
		next_lp_cnt    = codec_tx_enable ? 21'h0 : lp_cnt + 21'h1;
		if (!codec_tx_enable && lp_cnt == LP_PERIOD_CYC - 21'h1)
			next_lp_cnt = 21'h0;
		next_loss_cnt  = loss_cnt;
		next_link_fail = link_fail;
		if ((lp_seen && !lp_seen_q) || rx_data_valid)
		begin
			next_loss_cnt  = 24'h0;
			next_link_fail = 1'b0;
		end
		else if (loss_cnt == LINK_LOSS_CYC - 24'h1)
			next_link_fail = 1'b1;
		else
			next_loss_cnt = loss_cnt + 24'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lp_cnt    <= 21'h0;
			loss_cnt  <= 24'h0;
			link_fail <= 1'b1;
			lp_seen_q <= 1'b0;
		end
		else
		begin
			lp_cnt    <= next_lp_cnt;
			loss_cnt  <= next_loss_cnt;
			link_fail <= next_link_fail;
			lp_seen_q <= lp_seen;
		end
	end

	// smart squelch sequencer; one timer serves the window and end-of-packet checks
	tps_pkg::tps_sq_state_t sq_state;
	tps_pkg::tps_sq_state_t next_sq_state;
	logic [4:0] sq_tmr;
	logic [4:0] next_sq_tmr;
	logic       first_neg;
	logic       next_first_neg;
	logic       polarity;
	logic       next_polarity;
	logic       opp;
	logic       orig;
	assign opp  = first_neg ? sq_pos : sq_neg;
	assign orig = first_neg ? sq_neg : sq_pos;

	always_comb
	begin
		next_sq_state  = sq_state;
		next_sq_tmr    = sq_tmr + 5'h1;
		next_first_neg = first_neg;
		next_polarity  = polarity;
		unique case (sq_state)
			tps_pkg::SQ_IDLE:
			begin
				next_sq_tmr = 5'h0;
				if (sq_pos || sq_neg)
				begin
					next_first_neg = !sq_pos;
					next_sq_state  = tps_pkg::SQ_WAIT_OPP;
				end
			end
			tps_pkg::SQ_WAIT_OPP:
			begin
				if (opp)
				begin
					next_sq_tmr   = 5'h0;
					next_sq_state = tps_pkg::SQ_WAIT_ORIG;
				end
				else if (sq_tmr == SQ_WIN)
					next_sq_state = tps_pkg::SQ_IDLE;
			end
			tps_pkg::SQ_WAIT_ORIG:
			begin
				if (orig)
				begin
					next_sq_tmr   = 5'h0;
					next_polarity = first_neg;
					next_sq_state = tps_pkg::SQ_VALID;
				end
				else if (sq_tmr == SQ_WIN)
					next_sq_state = tps_pkg::SQ_IDLE;
			end
			tps_pkg::SQ_VALID:
			begin
				if (sq_pos || sq_neg)
					next_sq_tmr = 5'h0;
				else if (sq_tmr == SQ_WIN)
					next_sq_state = tps_pkg::SQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sq_state  <= tps_pkg::SQ_IDLE;
			sq_tmr    <= 5'h0;
			first_neg <= 1'b0;
			polarity  <= 1'b0;
		end
		else
		begin
			sq_state  <= next_sq_state;
			sq_tmr    <= next_sq_tmr;
			first_neg <= next_first_neg;
			polarity  <= next_polarity;
		end
	end

	// activity, gated by link integrity
	logic rx_act;
	logic tx_act;
	logic col_cond;
	assign rx_act   = (sq_state == tps_pkg::SQ_VALID) && link_ok;
	assign tx_act   = codec_tx_enable && !jab && link_ok;
	assign col_cond = rx_act && tx_act;

	// collision qualifier; noise while transmitting is filtered for seven bits
	logic [6:0] col_cnt;
	logic [6:0] next_col_cnt;
	logic       col_flag;
	logic       next_col_flag;
	logic       tx_lead;
	logic       next_tx_lead;

	always_comb
	begin
		next_col_cnt  = 7'h0;
		next_col_flag = 1'b0;
		next_tx_lead  = tx_act && !rx_act;
		if (col_cond)
		begin
			next_tx_lead  = tx_lead;
			next_col_flag = col_flag || !tx_lead;
			next_col_cnt  = col_cnt;
			if (tx_lead && !col_flag)
			begin
				next_col_cnt  = col_cnt + 7'h1;
				next_col_flag = (col_cnt == COL_CYC - 7'h1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			col_cnt  <= 7'h0;
			col_flag <= 1'b0;
			tx_lead  <= 1'b0;
		end
		else
		begin
			col_cnt  <= next_col_cnt;
			col_flag <= next_col_flag;
			tx_lead  <= next_tx_lead;
		end
	end

	// heartbeat: delay after transmit end, then ten 10 MHz cycles
	logic [7:0] hb_tmr;
	logic [7:0] next_hb_tmr;
	logic [3:0] hb_ph;
	logic [3:0] next_hb_ph;
	logic       hb_on;
	logic       next_hb_on;
	logic       hb_lvl;
	logic       next_hb_lvl;
	logic       tx_en_q;

	always_comb
	begin
		next_hb_tmr = hb_tmr;
		next_hb_on  = hb_on;
		next_hb_ph  = 4'h0;
		next_hb_lvl = 1'b0;
		if (tx_en_q && !codec_tx_enable)
		begin
			next_hb_tmr = 8'h1;
			next_hb_on  = 1'b1;
		end
		else if (hb_on)
		begin
			next_hb_on  = (hb_tmr != HB_END);
			next_hb_tmr = hb_tmr + 8'h1;
			if (hb_tmr > HB_DLY)
			begin
				// square wave, high for the first half of each period
				next_hb_ph  = (hb_ph == 2 * HB_HALF - 4'h1) ? 4'h0 : hb_ph + 4'h1;
				next_hb_lvl = (hb_ph < HB_HALF);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hb_tmr  <= 8'h0;
			hb_ph   <= 4'h0;
			hb_on   <= 1'b0;
			hb_lvl  <= 1'b0;
			tx_en_q <= 1'b0;
		end
		else
		begin
			hb_tmr  <= next_hb_tmr;
			hb_ph   <= next_hb_ph;
			hb_on   <= next_hb_on;
			hb_lvl  <= next_hb_lvl;
			tx_en_q <= codec_tx_enable;
		end
	end

	// jabber and unjab; one counter, reused for both phases
	logic [26:0] jab_cnt;
	logic [26:0] next_jab_cnt;
	logic        next_jab;

	always_comb
	begin
		next_jab     = jab;
		next_jab_cnt = jab_cnt + 27'h1;
		if (!jab)
		begin
			if (!codec_tx_enable)
				next_jab_cnt = 27'h0;
			else if (jab_cnt == JAB_CYC)
			begin
				next_jab     = 1'b1;
				next_jab_cnt = 27'h0;
			end
		end
		else if (codec_tx_enable)
			next_jab_cnt = 27'h0;
		else if (jab_cnt == UNJAB_CYC - 27'h1)
		begin
			next_jab     = 1'b0;
			next_jab_cnt = 27'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			jab     <= 1'b0;
			jab_cnt <= 27'h0;
		end
		else
		begin
			jab     <= next_jab;
			jab_cnt <= next_jab_cnt;
		end
	end

	// line drivers and pre-emphasis delay line; idle pair sits at zero differential except during link pulses on the p line
	logic [2*PRE_N-3:0] pre_dly;
	logic               next_txp;
	logic               next_txn;
	always_comb
	begin
		next_txp = tx_act ? codec_tx_data : (lp_on && !jab);
		next_txn = tx_act && !codec_tx_data;
	end

	assign status = {jab, polarity, link_ok, col_flag, tx_act, rx_act};

	// registered outputs toward the codec, line and lamps
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pre_dly                     <= '0;
			tx_line_pair_p              <= 1'b0;
			tx_line_pair_n              <= 1'b0;
			tx_line_pair_delayed_p      <= 1'b0;
			tx_line_pair_delayed_n      <= 1'b0;
			rx_data_valid               <= 1'b0;
			mac_collision               <= 1'b0;
			sqe_heartbeat               <= 1'b0;
			squelch_level_sel           <= 2'h0;
			receive_activity_indicator  <= 1'b0;
			transmit_activity_indicator <= 1'b0;
			collision_indicator         <= 1'b0;
			link_good_indicator         <= 1'b0;
			polarity_indicator          <= 1'b0;
		end
		else
		begin
			pre_dly                     <= {pre_dly[2*PRE_N-5:0], tx_line_pair_p, tx_line_pair_n};
			tx_line_pair_p              <= next_txp;
			tx_line_pair_n              <= next_txn;
			tx_line_pair_delayed_p      <= pre_dly[2*PRE_N-3];
			tx_line_pair_delayed_n      <= pre_dly[2*PRE_N-4];
			rx_data_valid               <= rx_act;
			mac_collision               <= col_flag || hb_lvl;
			sqe_heartbeat               <= hb_lvl;
			// level select: bit1 mode, bit0 lowered in-packet levels
			squelch_level_sel           <= {reduced_squelch_select, sq_state == tps_pkg::SQ_VALID};
			receive_activity_indicator  <= rx_act;
			transmit_activity_indicator <= tx_act;
			collision_indicator         <= col_flag;
			link_good_indicator         <= link_ok;
			polarity_indicator          <= polarity;
		end
	end

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_sq_opp;
		sq_state == tps_pkg::SQ_WAIT_OPP && !opp && sq_tmr == SQ_WIN |=> sq_state == tps_pkg::SQ_IDLE;
	endproperty
	a_sq_opp: assert property (p_sq_opp) else $error("squelch opposite window not enforced");

	property p_sq_orig;
		sq_state == tps_pkg::SQ_WAIT_ORIG && !orig && sq_tmr == SQ_WIN |=> sq_state == tps_pkg::SQ_IDLE;
	endproperty
	a_sq_orig: assert property (p_sq_orig) else $error("squelch original window not enforced");

	property p_valid_entry;
		sq_state != tps_pkg::SQ_VALID ##1 sq_state == tps_pkg::SQ_VALID
			|-> $past(sq_state) == tps_pkg::SQ_WAIT_ORIG && sq_tmr == 5'h0;
	endproperty
	a_valid_entry: assert property (p_valid_entry) else $error("valid without full sequence");

	// quiet cycles in valid, counted so the end-of-packet check needs no long repetition
	logic [4:0] eop_quiet;
	logic [4:0] next_eop_quiet;
	always_comb
	begin
		next_eop_quiet = 5'h0;
		if (sq_state == tps_pkg::SQ_VALID && !sq_pos && !sq_neg)
			next_eop_quiet = eop_quiet + 5'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			eop_quiet <= 5'h0;
		else
			eop_quiet <= next_eop_quiet;
	end

	property p_eop;
		eop_quiet == 5'h10 |-> sq_state == tps_pkg::SQ_IDLE;
	endproperty
	a_eop: assert property (p_eop) else $error("end of packet missed");

	property p_col_rx;
		col_cond && !tx_lead |=> col_flag;
	endproperty
	a_col_rx: assert property (p_col_rx) else $error("receive collision not immediate");

	property p_col_tx;
		col_cond && tx_lead && col_cnt < COL_CYC - 7'h1 |=> !col_flag;
	endproperty
	a_col_tx: assert property (p_col_tx) else $error("transmit collision reported early");

	property p_col_hold;
		col_flag && col_cond |=> col_flag ##1 collision_indicator;
	endproperty
	a_col_hold: assert property (p_col_hold) else $error("collision dropped while present");

	property p_hb;
		$fell(codec_tx_enable) && !hb_on |-> ##[100:104] sqe_heartbeat;
	endproperty
	a_hb: assert property (p_hb) else $error("heartbeat missing after transmit");

	property p_jab_hold;
		jab && codec_tx_enable |=> jab && !tx_line_pair_n;
	endproperty
	a_jab_hold: assert property (p_jab_hold) else $error("transmitter released while enabled");

	property p_link_gate;
		!link_ok |=> !rx_data_valid && !tx_line_pair_n && !transmit_activity_indicator;
	endproperty
	a_link_gate: assert property (p_link_gate) else $error("traffic passed without link");

	property p_pre;
		tx_line_pair_delayed_p == $past(tx_line_pair_p, 5) && tx_line_pair_delayed_n == $past(tx_line_pair_n, 5);
	endproperty
	a_pre: assert property (p_pre) else $error("pre-emphasis copy not 50 ns late");

	c_valid: cover property ($rose(rx_data_valid));
	c_col_tx: cover property (col_cond && tx_lead ##1 col_flag);
	c_hb: cover property ($rose(sqe_heartbeat));
	c_jab: cover property ($rose(jab));

endmodule : tps_link_supervisor

// File: core/tps_cfg.svh
// constants of the twisted pair link supervisor: offsets, fields, resets, timing
// assumes a 100 MHz pclk; times are kept in their own unit and turned into cycles
`ifndef TPS_CFG_SVH
`define TPS_CFG_SVH

// clock
`define TPS_CLK_NS          10

// register byte offsets
`define TPS_OFS_CTRL        12'h000
`define TPS_OFS_STATUS      12'h004

// control fields and reset value
`define TPS_CTRL_REDUCED    0
`define TPS_CTRL_LINK_OFF   1
`define TPS_CTRL_RESET      2'h0

// status fields
`define TPS_ST_RX           0
`define TPS_ST_TX           1
`define TPS_ST_COL          2
`define TPS_ST_LINK         3
`define TPS_ST_POL          4
`define TPS_ST_JAB          5

// times as printed
`define TPS_SQ_WIN_NS       150
`define TPS_COL_BITS        7
`define TPS_BIT_NS          100
`define TPS_HB_DLY_NS       1000
`define TPS_HB_CYCLES       10
`define TPS_HB_HALF_NS      50
`define TPS_LP_W_NS         100
`define TPS_LP_PERIOD_MS    16
`define TPS_LINK_LOSS_MS    100
`define TPS_JAB_MS          26
`define TPS_UNJAB_MS        750
`define TPS_PRE_DLY_NS      50

// derived cycle counts (longest times round down, least times round up)
`define TPS_SQ_WIN_CYC      (`TPS_SQ_WIN_NS / `TPS_CLK_NS)
`define TPS_COL_CYC         ((`TPS_COL_BITS * `TPS_BIT_NS + `TPS_CLK_NS - 1) / `TPS_CLK_NS)
`define TPS_HB_DLY_CYC      (`TPS_HB_DLY_NS / `TPS_CLK_NS)
`define TPS_HB_HALF_CYC     (`TPS_HB_HALF_NS / `TPS_CLK_NS)
`define TPS_HB_LEN_CYC      (2 * `TPS_HB_CYCLES * `TPS_HB_HALF_CYC)
`define TPS_LP_W_CYC        (`TPS_LP_W_NS / `TPS_CLK_NS)
`define TPS_LP_PERIOD_CYC   (`TPS_LP_PERIOD_MS * 1000000 / `TPS_CLK_NS)
`define TPS_LINK_LOSS_CYC   (`TPS_LINK_LOSS_MS * 1000000 / `TPS_CLK_NS)
`define TPS_JAB_CYC         (`TPS_JAB_MS * 1000000 / `TPS_CLK_NS)
`define TPS_UNJAB_CYC       (`TPS_UNJAB_MS * 1000000 / `TPS_CLK_NS)
`define TPS_PRE_DLY_CYC     (`TPS_PRE_DLY_NS / `TPS_CLK_NS)

`endif

// File: core/tps_pkg.sv
// types of the twisted pair link supervisor
// assumes tps_cfg.svh supplies all numeric constants
package tps_pkg;

	// squelch qualification sequencer, one-hot
	typedef enum logic [3:0] {
		SQ_IDLE      = 4'h1,
		SQ_WAIT_OPP  = 4'h2,
		SQ_WAIT_ORIG = 4'h4,
		SQ_VALID     = 4'h8
	} tps_sq_state_t;

endpackage : tps_pkg

// File: verification/tps_cable_model.sv
// remote transceiver as seen by the receive comparators and the link pulse detector
// assumes pclk at 100 MHz; comparator outputs rest low between crossings
`timescale 1ns/100ps

module tps_cable_model (
	input  wire logic pclk,
	output logic      sq_pos,
	output logic      sq_neg,
	output logic      lp_rx
);
	// quiet line at time zero
	initial
	begin
		sq_pos = 1'b0;
		sq_neg = 1'b0;
		lp_rx  = 1'b0;
	end

	// k alternating crossings on a 5 cycle half-bit pitch; held 3 cycles to pass the filter
	task burst(input int k, input logic neg_first);
		int i;
		for (i = 0; i < k; i++)
		begin
			@(posedge pclk);
			if (i[0] ^ neg_first)
				sq_neg <= 1'b1;
			else
				sq_pos <= 1'b1;
			repeat (3) @(posedge pclk);
			sq_pos <= 1'b0;
			sq_neg <= 1'b0;
			@(posedge pclk);
		end
	endtask : burst

	// one link pulse, wider than the input filter needs
	task pulse;
		@(posedge pclk);
		lp_rx <= 1'b1;
		repeat (10) @(posedge pclk);
		lp_rx <= 1'b0;
	endtask : pulse
endmodule : tps_cable_model

// File: verification/tb_top.sv
// self-checking bench of the link supervisor with shortened link and jabber counts
// assumes the cable model drives the receive side; apb answers are waited for
`timescale 1ns/100ps

module tb_top;
	logic        pclk;
	logic        presetn;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sq_pos;
	logic        sq_neg;
	logic        lp_rx;
	logic        tx_en;
	logic        tx_d;
	logic        rx_data_valid;
	logic        mac_collision;
	logic        sqe_heartbeat;
	logic [1:0]  squelch_level_sel;
	logic        txp;
	logic        txn;
	logic        txdp;
	logic        txdn;
	logic        rx_ind;
	logic        tx_ind;
	logic        col_ind;
	logic        link_ind;
	logic        pol_ind;
	logic [4:0]  hist;
	logic [3:0]  dcnt;
	logic        pre_on;
	logic [31:0] rd;
	logic        er;
	int          failures;
	int          n_checks;

	tps_link_supervisor #(.LP_PERIOD_CYC(21'h0000c8), .LINK_LOSS_CYC(24'h0001f4), .JAB_CYC(27'h000012c),
		.UNJAB_CYC(27'h0000190)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_squelch_pos(sq_pos), .rx_squelch_neg(sq_neg),
		.link_pulse_rx(lp_rx), .codec_tx_enable(tx_en), .codec_tx_data(tx_d),
		.rx_data_valid(rx_data_valid), .mac_collision(mac_collision), .sqe_heartbeat(sqe_heartbeat),
		.squelch_level_sel(squelch_level_sel), .tx_line_pair_p(txp), .tx_line_pair_n(txn),
		.tx_line_pair_delayed_p(txdp), .tx_line_pair_delayed_n(txdn),
		.receive_activity_indicator(rx_ind), .transmit_activity_indicator(tx_ind),
		.collision_indicator(col_ind), .link_good_indicator(link_ind), .polarity_indicator(pol_ind));

	tps_cable_model cable (.pclk(pclk), .sq_pos(sq_pos), .sq_neg(sq_neg), .lp_rx(lp_rx));

	// 100 MHz clock
	always #5 pclk = ~pclk;

	task chk(input string n, input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, x, g);
		end
	endtask : chk

	task give_verdict;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	// square wave codec data; the line history lets the delayed copy be judged every cycle
	always @(posedge pclk)
	begin
		dcnt <= (dcnt == 4'h9) ? 4'h0 : dcnt + 4'h1;
		tx_d <= (dcnt < 4'h5);
		hist <= {hist[3:0], txp};
		if (pre_on)
		begin
			chk("delayed", 32'(txdp), 32'(hist[4]));
			chk("delayed_n", 32'(txdn), 32'(!hist[4]));
			chk("compl", 32'(txn), 32'(!txp));
		end
	end

	// one apb transfer; no answer time assumed, the wait is only bounded
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		chk("pready", 32'(pready), 32'h1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// receive watch: first and last valid cycle, valid count, unlowered thresholds
	task mon(input int n, output int first, output int last, output int hi, output int bad);
		int i;
		first = -1;
		hi = 0;
		bad = 0;
		for (i = 0; i < n; i++)
		begin
			@(posedge pclk);
			if (rx_data_valid === 1'b1)
			begin
				if (first < 0) first = i;
				last = i;
				hi++;
				if (squelch_level_sel[0] !== 1'b1) bad++;
				if (rx_ind !== 1'b1) bad++;
			end
		end
	endtask : mon

	task t_regs;
		chk("link_rst", 32'(link_ind), 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl_rst", rd, 32'h0);
		apb(1'b1, 12'h000, 32'h3);
		pstrb <= 4'h0;
		apb(1'b1, 12'h000, 32'h0);
		pstrb <= 4'hf;
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl_rw", rd, 32'h3);
		apb(1'b0, 12'h008, 32'h0);
		chk("unmapped", {rd[30:0], er}, 32'h1);
		apb(1'b1, 12'h000, 32'h0);
	endtask : t_regs

	task t_link;
		int i, run, w, np, f, l, h, b;
		run = 0;
		np = 0;
		w = 0;
		for (i = 0; i < 600; i++)
		begin
			@(posedge pclk);
			if (txp === 1'b1) run++;
			else if (run > 0)
			begin
				w = run;
				np++;
				run = 0;
			end
		end
		chk("lp_width", w, 10);
		chk("lp_count", 32'(np >= 2), 32'h1);
		chk("link_lost", 32'(link_ind), 32'h0);
		fork
			cable.burst(20, 1'b0);
			mon(160, f, l, h, b);
		join
		chk("rx_gated", h, 0);
		cable.pulse;
		repeat (6) @(posedge pclk);
		chk("link_good", 32'(link_ind), 32'h1);
		apb(1'b1, 12'h000, 32'h2);
		repeat (600) @(posedge pclk);
		chk("link_bypass", 32'(link_ind), 32'h1);
	endtask : t_link

	task t_sq;
		int ks[4] = '{1, 2, 3, 40};
		int m, j, f, l, h, b;
		for (m = 0; m < 2; m++)
		begin
			apb(1'b1, 12'h000, {30'h0, 1'b1, m[0]});
			repeat (2) @(posedge pclk);
			chk("mode", 32'(squelch_level_sel[1]), 32'(m));
			for (j = 0; j < 4; j++)
			begin
				fork
					cable.burst(ks[j], m[0]);
					mon(5 * ks[j] + 60, f, l, h, b);
				join
				chk("accept", 32'(h > 0), 32'(ks[j] > 2));
				if (ks[j] > 2)
				begin
					chk("valid_end", 32'(l >= 5 * ks[j] + 16), 32'h1);
					chk("valid_run", h, l - f + 1);
					chk("lowered", b, 0);
					chk("polarity", 32'(pol_ind), 32'(m));
				end
			end
		end
		apb(1'b1, 12'h000, 32'h2);
	endtask : t_sq

	task t_col_rx;
		int i, bad;
		fork
			cable.burst(40, 1'b0);
			begin
				repeat (40) @(posedge pclk);
				tx_en <= 1'b1;
				i = 0;
				do
				begin
					@(posedge pclk);
					i++;
				end
				while (mac_collision !== 1'b1 && i < 20);
				chk("col_rx", 32'(i <= 4), 32'h1);
				bad = 0;
				repeat (100)
				begin
					@(posedge pclk);
					if (mac_collision !== 1'b1 || col_ind !== 1'b1) bad++;
				end
				chk("col_hold", bad, 0);
				tx_en <= 1'b0;
			end
		join
		repeat (300) @(posedge pclk);
	endtask : t_col_rx

	task t_hb;
		int i, f, n;
		logic prv;
		tx_en <= 1'b1;
		repeat (50) @(posedge pclk);
		chk("tx_ind", 32'(tx_ind), 32'h1);
		tx_en <= 1'b0;
		f = -1;
		n = 0;
		prv = 1'b0;
		for (i = 0; i < 300; i++)
		begin
			@(posedge pclk);
			if (sqe_heartbeat === 1'b1 && prv !== 1'b1)
			begin
				n++;
				if (f < 0) f = i;
			end
			prv = sqe_heartbeat;
		end
		chk("hb_count", n, 10);
		chk("hb_delay", 32'(f >= 90 && f <= 115), 32'h1);
	endtask : t_hb

	task t_col_tx;
		int i;
		tx_en <= 1'b1;
		repeat (10) @(posedge pclk);
		fork
			cable.burst(30, 1'b0);
			begin
				i = 0;
				do
				begin
					@(posedge pclk);
					i++;
				end
				while (mac_collision !== 1'b1 && i < 150);
			end
		join
		chk("col_tx", 32'(i >= 70 && i <= 100), 32'h1);
		tx_en <= 1'b0;
		repeat (300) @(posedge pclk);
	endtask : t_col_tx

	task t_jab;
		int act;
		tx_en <= 1'b1;
		repeat (20) @(posedge pclk);
		pre_on <= 1'b1;
		repeat (250) @(posedge pclk);
		pre_on <= 1'b0;
		repeat (60) @(posedge pclk);
		act = 0;
		repeat (20)
		begin
			@(posedge pclk);
			if (txp !== 1'b0 || txn !== 1'b0) act++;
		end
		chk("jab_quiet", act, 0);
		apb(1'b0, 12'h004, 32'h0);
		chk("jab_flag", 32'(rd[5]), 32'h1);
		tx_en <= 1'b0;
		repeat (380) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		chk("unjab_early", 32'(rd[5]), 32'h1);
		repeat (30) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		chk("unjab", 32'(rd[5]), 32'h0);
	endtask : t_jab

	// reset, then the scenarios in turn
	initial
	begin
		pclk     = 1'b0;
		presetn  = 1'b0;
		psel     = 1'b0;
		penable  = 1'b0;
		pwrite   = 1'b0;
		paddr    = 12'h000;
		pwdata   = 32'h0;
		pstrb    = 4'hf;
		tx_en    = 1'b0;
		tx_d     = 1'b0;
		dcnt     = 4'h0;
		hist     = 5'h00;
		pre_on   = 1'b0;
		failures = 0;
		n_checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_link;
		t_sq;
		t_col_rx;
		t_hb;
		t_col_tx;
		t_jab;
		give_verdict;
	end

	// hang guard, far past the few thousand cycles the sequence needs
	initial
	begin
		#200000;
		failures++;
		give_verdict;
	end
endmodule : tb_top
